// [src/pmbsr_regs.sv]
// pmbus misc/vendor status bytes and input/output voltage telemetry words
`default_nettype none
`include "pmbsr_cfg.svh"

module pmbsr_regs
   import pmbsr_pkg::*;
#(
   parameter int NUM_PHASES = 4,
   parameter int TELEM_CYC = `PMBSR_TELEM_CYC
) (
   // core clock and reset
   input wire logic core_clk_i,
   input wire logic resetn_i,
   // link side transaction port
   input wire logic link_clk_i,
   input wire logic lk_req_i,
   input wire logic [7:0] lk_cmd_i,
   input wire logic lk_write_i,
   input wire logic [15:0] lk_wdata_i,
   output logic lk_busy_o,
   output logic lk_ack_o,
   output logic [15:0] lk_rdata_o,
   output logic lk_claim_o,
   // fault and event sources, core clock
   input wire logic trim_check_bad_i,
   input wire logic store_checksum_bad_i,
   input wire logic strap_detect_bad_i,
   input wire logic self_check_busy_i,
   input wire logic followers_pending_i,
   input wire logic output_restore_event_i,
   input wire logic backchannel_fault_i,
   input wire logic sync_fault_i,
   input wire logic is_follower_i,
   // alert suppress masks from the alert_suppress_cmd register
   input wire logic [7:0] alert_suppress_misc_i,
   input wire logic [7:0] alert_suppress_vendor_i,
   // telemetry sources
   input wire logic [7:0] phase_sel_i,
   input wire logic [15:0] ctrl_power_input_supply_i,
   input wire logic [NUM_PHASES-1:0][15:0] phase_power_input_supply_i,
   input wire logic [15:0] vout_meas_i,
   // alert pin, open drain
   input wire logic alert_i,
   output logic alert_o,
   output logic alert_oe_o,
   // links to other status logic
   output logic sum_misc_o,
   output logic sum_vendor_o,
   output logic invalid_command_flag_o,
   output logic cml_comm_fault_o
);
   localparam int CNT_W = $clog2(TELEM_CYC + 1);
   localparam int PH_W = (NUM_PHASES > 1) ? $clog2(NUM_PHASES) : 1;
   localparam logic [CNT_W-1:0] CNT_RELOAD = CNT_W'(TELEM_CYC - 1);

   // ---------------- link domain ----------------
   pmbsr_lk_state_t lk_state_q;
   pmbsr_lk_state_t lk_state_d;
   pmbsr_req_t lk_hold_q;
   pmbsr_req_t lk_hold_d;
   logic lk_req_tgl_q;
   logic lk_req_tgl_d;
   logic lk_ack_seen_q;
   logic lk_ack_seen_d;
   logic lk_ack_q;
   logic lk_ack_d;
   logic [15:0] lk_rdata_q;
   logic [15:0] lk_rdata_d;
   logic lk_claim_q;
   logic lk_claim_d;
   logic lk_ack_tgl_s;

   // ---------------- core domain ----------------
   pmbsr_rsp_t rsp_q;
   pmbsr_rsp_t rsp_d;
   logic req_tgl_s;
   logic req_seen_q;
   logic req_seen_d;
   logic ack_tgl_q;
   logic ack_tgl_d;
   logic first_q;
   logic first_d;
   logic [7:0] vf_lat_q;
   logic [7:0] vf_lat_d;
   logic alert_drv_q;
   logic alert_drv_d;
   logic ivc_q;
   logic ivc_d;
   logic comm_q;
   logic comm_d;
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   logic [15:0] vin_q;
   logic [15:0] vin_d;
   logic [15:0] vout_q;
   logic [15:0] vout_d;
   logic alert_bus_s;

   // request toggle into core, answer toggle back to link
   pmbsr_sync #(.WIDTH(1), .RESET_VAL(1'b0)) u_req_sync (
      .clk_i(core_clk_i),
      .resetn_i(resetn_i),
      .d_i(lk_req_tgl_q),
      .q_o(req_tgl_s)
   );

   pmbsr_sync #(.WIDTH(1), .RESET_VAL(1'b0)) u_ack_sync (
      .clk_i(link_clk_i),
      .resetn_i(resetn_i),
      .d_i(ack_tgl_q),
      .q_o(lk_ack_tgl_s)
   );

   // alert wire idles high
   pmbsr_sync #(.WIDTH(1), .RESET_VAL(1'b1)) u_alert_sync (
      .clk_i(core_clk_i),
      .resetn_i(resetn_i),
      .d_i(alert_i),
      .q_o(alert_bus_s)
   );

   // link side: hold the request stable until the core answers
   always_comb begin
      lk_state_d = lk_state_q;
      lk_hold_d = lk_hold_q;
      lk_req_tgl_d = lk_req_tgl_q;
      lk_ack_seen_d = lk_ack_seen_q;
      lk_ack_d = 1'b0;
      lk_rdata_d = lk_rdata_q;
      lk_claim_d = lk_claim_q;
      case (lk_state_q)
         PMBSR_LK_IDLE: begin
            if (lk_req_i) begin
               lk_hold_d.cmd = lk_cmd_i;
               lk_hold_d.write = lk_write_i;
               lk_hold_d.wdata = lk_wdata_i;
               lk_req_tgl_d = ~lk_req_tgl_q;
               lk_state_d = PMBSR_LK_WAIT;
            end
         end
         PMBSR_LK_WAIT: begin
            // answer word is stable in the core while its toggle crosses
            if (lk_ack_tgl_s != lk_ack_seen_q) begin
               lk_ack_seen_d = lk_ack_tgl_s;
               lk_rdata_d = rsp_q.rdata;
               lk_claim_d = rsp_q.claim;
               lk_ack_d = 1'b1;
               lk_state_d = PMBSR_LK_IDLE;
            end
         end
         default: begin
            lk_state_d = PMBSR_LK_IDLE;
         end
      endcase
   end

   always_ff @(posedge link_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         lk_state_q <= PMBSR_LK_IDLE;
         lk_hold_q <= '0;
         lk_req_tgl_q <= 1'b0;
         lk_ack_seen_q <= 1'b0;
         lk_ack_q <= 1'b0;
         lk_rdata_q <= 16'h0000;
         lk_claim_q <= 1'b0;
      end else begin
         lk_state_q <= lk_state_d;
         lk_hold_q <= lk_hold_d;
         lk_req_tgl_q <= lk_req_tgl_d;
         lk_ack_seen_q <= lk_ack_seen_d;
         lk_ack_q <= lk_ack_d;
         lk_rdata_q <= lk_rdata_d;
         lk_claim_q <= lk_claim_d;
      end
   end

   // core side: command decode, status latches, telemetry
   always_comb begin
      logic new_req;
      logic wr;
      logic clear_all;
      logic clr_first;
      logic alert_req;
      logic [7:0] vf_set;
      logic [7:0] vf_clr;
      logic [7:0] misc_rd;
      logic [7:0] vf_rd;
      logic [15:0] vin_sel;
      new_req = (req_tgl_s != req_seen_q);
      wr = new_req & lk_hold_q.write;
      clear_all = wr & (lk_hold_q.cmd == `PMBSR_CMD_CLEAR_FAULTS);
      clr_first = clear_all;
      vf_clr = clear_all ? `PMBSR_VF_LATCH_MASK : 8'h00;
      if (wr && lk_hold_q.cmd == `PMBSR_CMD_MISC_ALERT && lk_hold_q.wdata[`PMBSR_MISC_FIRST_BIT]) begin
         clr_first = 1'b1;
      end
      if (wr && lk_hold_q.cmd == `PMBSR_CMD_VENDOR_FAULT) begin
         vf_clr = lk_hold_q.wdata[7:0] & `PMBSR_VF_LATCH_MASK;
      end
      vf_set = 8'h00;
      vf_set[`PMBSR_VF_POR_BIT] = trim_check_bad_i | store_checksum_bad_i | strap_detect_bad_i;
      vf_set[`PMBSR_VF_RESTORE_BIT] = output_restore_event_i;
      vf_set[`PMBSR_VF_BCX_BIT] = backchannel_fault_i;
      vf_set[`PMBSR_VF_SYNC_BIT] = sync_fault_i;
      // set beats a clear landing in the same cycle
      vf_lat_d = ((vf_lat_q & ~vf_clr) | vf_set) & `PMBSR_VF_LATCH_MASK;
      alert_req = |(vf_lat_q & ~alert_suppress_vendor_i & `PMBSR_VF_LATCH_MASK);
      alert_drv_d = alert_req;
      // first only if nobody else already holds the wire low
      first_d = (first_q & ~clr_first) | (alert_req & ~alert_drv_q & alert_bus_s);
      misc_rd = `PMBSR_MISC_RESET;
      misc_rd[`PMBSR_MISC_FIRST_BIT] = first_q;
      vf_rd = vf_lat_q;
      vf_rd[`PMBSR_VF_SELF_BIT] = self_check_busy_i | followers_pending_i;
      ivc_d = wr && (lk_hold_q.cmd == `PMBSR_CMD_VIN_READ || lk_hold_q.cmd == `PMBSR_CMD_VOUT_READ);
      comm_d = backchannel_fault_i & is_follower_i;
      req_seen_d = req_tgl_s;
      ack_tgl_d = new_req ? ~ack_tgl_q : ack_tgl_q;
      rsp_d = rsp_q;
      if (new_req) begin
         rsp_d.claim = 1'b1;
         case (lk_hold_q.cmd)
            `PMBSR_CMD_MISC_ALERT: rsp_d.rdata = {8'h00, misc_rd};
            `PMBSR_CMD_VENDOR_FAULT: rsp_d.rdata = {8'h00, vf_rd};
            `PMBSR_CMD_VIN_READ: rsp_d.rdata = vin_q;
            `PMBSR_CMD_VOUT_READ: rsp_d.rdata = vout_q;
            `PMBSR_CMD_CLEAR_FAULTS: rsp_d.rdata = 16'h0000;
            default: begin
               rsp_d.rdata = 16'h0000;
               rsp_d.claim = 1'b0;
            end
         endcase
      end
      // out-of-range phase falls back to the controller's reading
      vin_sel = ctrl_power_input_supply_i;
      if (phase_sel_i != `PMBSR_PHASE_ALL && {24'h000000, phase_sel_i} < NUM_PHASES) begin
         vin_sel = phase_power_input_supply_i[phase_sel_i[PH_W-1:0]];
      end
      cnt_d = cnt_q - CNT_W'(1);
      vin_d = vin_q;
      vout_d = vout_q;
      if (cnt_q == '0) begin
         cnt_d = CNT_RELOAD;
         vin_d = vin_sel;
         vout_d = vout_meas_i;
      end
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rsp_q <= '0;
         req_seen_q <= 1'b0;
         ack_tgl_q <= 1'b0;
         first_q <= 1'b0;
         vf_lat_q <= `PMBSR_VF_RESET;
         alert_drv_q <= 1'b0;
         ivc_q <= 1'b0;
         comm_q <= 1'b0;
         cnt_q <= '0;
         vin_q <= 16'h0000;
         vout_q <= 16'h0000;
      end else begin
         rsp_q <= rsp_d;
         req_seen_q <= req_seen_d;
         ack_tgl_q <= ack_tgl_d;
         first_q <= first_d;
         vf_lat_q <= vf_lat_d;
         alert_drv_q <= alert_drv_d;
         ivc_q <= ivc_d;
         comm_q <= comm_d;
         cnt_q <= cnt_d;
         vin_q <= vin_d;
         vout_q <= vout_d;
      end
   end

   // link side outputs
   assign lk_busy_o = (lk_state_q == PMBSR_LK_WAIT);
   assign lk_ack_o = lk_ack_q;
   assign lk_rdata_o = lk_rdata_q;
   assign lk_claim_o = lk_claim_q;

   // open drain: only ever pulls low
   assign alert_o = 1'b0;
   assign alert_oe_o = alert_drv_q;

   assign sum_misc_o = first_q;
   assign sum_vendor_o = |vf_lat_q;
   assign invalid_command_flag_o = ivc_q;
   assign cml_comm_fault_o = comm_q;
endmodule : pmbsr_regs
`default_nettype wire

// [src/pmbsr_cfg.svh]
// constants for the pmbus status and telemetry register block
`ifndef PMBSR_CFG_SVH
`define PMBSR_CFG_SVH

// command codes
`define PMBSR_CMD_CLEAR_FAULTS 8'h03
`define PMBSR_CMD_MISC_ALERT 8'h7F
`define PMBSR_CMD_VENDOR_FAULT 8'h80
`define PMBSR_CMD_VIN_READ 8'h88
`define PMBSR_CMD_VOUT_READ 8'h8B

// misc alert status fields
`define PMBSR_MISC_FIRST_BIT 0
`define PMBSR_MISC_RESET 8'h00

// vendor fault status fields
`define PMBSR_VF_POR_BIT 7
`define PMBSR_VF_SELF_BIT 6
`define PMBSR_VF_RESTORE_BIT 3
`define PMBSR_VF_BCX_BIT 2
`define PMBSR_VF_SYNC_BIT 1
`define PMBSR_VF_LATCH_MASK 8'h8E
`define PMBSR_VF_RESET 8'h00

// phase selection that means the loop controller
`define PMBSR_PHASE_ALL 8'hFF

// telemetry refresh: period in microseconds, core clock in MHz
`define PMBSR_TELEM_PERIOD_US 1000
`define PMBSR_CORE_CLK_MHZ 25
`define PMBSR_TELEM_CYC (`PMBSR_TELEM_PERIOD_US * `PMBSR_CORE_CLK_MHZ)

`endif

// [src/pmbsr_pkg.sv]
// types shared by the pmbus status and telemetry register block
`default_nettype none
package pmbsr_pkg;

   // one pmbus transaction as handed over from the link side
   typedef struct packed {
      logic [7:0] cmd;
      logic write;
      logic [15:0] wdata;
   } pmbsr_req_t;

   // answer handed back to the link side
   typedef struct packed {
      logic [15:0] rdata;
      logic claim;
   } pmbsr_rsp_t;

   typedef enum logic [0:0] {
      PMBSR_LK_IDLE,
      PMBSR_LK_WAIT
   } pmbsr_lk_state_t;

endpackage : pmbsr_pkg
`default_nettype wire

// [src/pmbsr_sync.sv]
// three-stage synchroniser; output follows once stages two and three agree
`default_nettype none
module pmbsr_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // data
   input wire logic [WIDTH-1:0] d_i,
   output logic [WIDTH-1:0] q_o
);
   logic [WIDTH-1:0] s1_q;
   logic [WIDTH-1:0] s2_q;
   logic [WIDTH-1:0] s3_q;
   logic [WIDTH-1:0] q_q;
   logic [WIDTH-1:0] q_d;

   always_comb begin
      q_d = q_q;
      if (s2_q == s3_q) begin
         q_d = s3_q;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s1_q <= RESET_VAL;
         s2_q <= RESET_VAL;
         s3_q <= RESET_VAL;
         q_q <= RESET_VAL;
      end else begin
         s1_q <= d_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
         q_q <= q_d;
      end
   end

   assign q_o = q_q;
endmodule : pmbsr_sync
`default_nettype wire

// [verification/pmbsr_regs_chk.sv]
// port assertions for the status and telemetry register block
`default_nettype none
module pmbsr_regs_chk (
   // clocks
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input wire logic link_clk_i,
   // link
   input wire logic lk_req_i,
   input wire logic lk_busy_o,
   input wire logic lk_ack_o,
   // events
   input wire logic backchannel_fault_i,
   input wire logic is_follower_i,
   input wire logic sync_fault_i,
   input wire logic output_restore_event_i,
   input wire logic [7:0] alert_suppress_vendor_i,
   // status
   input wire logic alert_oe_o,
   input wire logic sum_vendor_o,
   input wire logic invalid_command_flag_o,
   input wire logic cml_comm_fault_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!resetn_i);

   a_follower_comm: assert property (backchannel_fault_i && is_follower_i |=> cml_comm_fault_o)
      else $error("no comm pulse");
   a_restore_sum: assert property (output_restore_event_i |-> ##[1:2] sum_vendor_o)
      else $error("no vendor summary");
   a_sync_alert: assert property (sync_fault_i && !alert_suppress_vendor_i[1] |-> ##[1:2] alert_oe_o)
      else $error("no alert");
   a_mask_quiet: assert property ((alert_suppress_vendor_i == 8'hFF) [*2] |-> !alert_oe_o)
      else $error("masked alert");
   a_invalid_pulse: assert property (invalid_command_flag_o |=> !invalid_command_flag_o)
      else $error("long invalid flag");
   a_take_busy: assert property (@(posedge link_clk_i) lk_req_i && !lk_busy_o |=> lk_busy_o)
      else $error("request not taken");
   a_ack_idle: assert property (@(posedge link_clk_i) lk_ack_o |-> !lk_busy_o && $past(lk_busy_o))
      else $error("stray ack");
   a_ack_bound: assert property (@(posedge link_clk_i) $rose(lk_busy_o) |-> ##[1:40] lk_ack_o)
      else $error("no answer");
endmodule : pmbsr_regs_chk

bind pmbsr_regs pmbsr_regs_chk chk_u (.core_clk_i, .resetn_i, .link_clk_i, .lk_req_i, .lk_busy_o, .lk_ack_o,
   .backchannel_fault_i, .is_follower_i, .sync_fault_i, .output_restore_event_i, .alert_suppress_vendor_i,
   .alert_oe_o, .sum_vendor_o, .invalid_command_flag_o, .cml_comm_fault_o);
`default_nettype wire

// [verification/pmbsr_host.sv]
// host model: gated link clock, one transaction at a time
`default_nettype none
module pmbsr_host
   import pmbsr_pkg::*;
(
   // request
   output logic link_clk_o,
   output logic lk_req_o,
   output logic [7:0] lk_cmd_o,
   output logic lk_write_o,
   output logic [15:0] lk_wdata_o,
   // answer
   input wire logic lk_busy_i,
   input wire logic lk_ack_i,
   input wire logic [15:0] lk_rdata_i,
   input wire logic lk_claim_i
);
   timeunit 1ns;
   timeprecision 1ps;
   bit run = 1'b1;

   initial {link_clk_o, lk_req_o, lk_cmd_o, lk_write_o, lk_wdata_o} = '0;
   // clock stands low between transactions
   always #6 if (run || link_clk_o) link_clk_o = ~link_clk_o;

   task automatic xfer(input pmbsr_req_t rq, output pmbsr_rsp_t rs);
      int n;
      run = 1'b1;
      repeat (2) @(negedge link_clk_o);
      lk_req_o = 1'b1;
      {lk_cmd_o, lk_write_o, lk_wdata_o} = rq;
      @(negedge link_clk_o);
      lk_req_o = 1'b0;
      // released lines flip so a stale value is never read as valid
      {lk_cmd_o, lk_write_o, lk_wdata_o} = ~rq;
      n = 0;
      // sample on the falling edge: ack is launched on the rising one
      do begin
         @(negedge link_clk_o);
         n++;
      end while (lk_ack_i !== 1'b1 && n < 40);
      rs = '{lk_rdata_i, lk_ack_i === 1'b1 ? lk_claim_i : 1'bx};
      @(negedge link_clk_o);
      run = 1'b0;
   endtask : xfer
endmodule : pmbsr_host
`default_nettype wire

// [verification/pmbsr_regs_tb.sv]
// bench for the status and telemetry register block
`default_nettype none
module pmbsr_regs_tb
   import pmbsr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TC = 50;
   logic core_clk_i, resetn_i, lclk, req, wr_l, busy, ack, claim, oth, aw, aoe, smisc, svf, invalid_command_flag, comm;
   logic [7:0] cmd, mask, phase;
   logic [15:0] wd, rdat, ctrl, vout;
   logic [8:0] ev;
   logic [3:0][15:0] ph;
   logic [7:0] vf_bit [8] = '{8'h80, 8'h80, 8'h80, 8'h40, 8'h40, 8'h08, 8'h04, 8'h02};
   int error_cnt, total_checks, ivc_cnt, comm_cnt;

   pmbsr_host host_u (.link_clk_o(lclk), .lk_req_o(req), .lk_cmd_o(cmd), .lk_write_o(wr_l), .lk_wdata_o(wd),
      .lk_busy_i(busy), .lk_ack_i(ack), .lk_rdata_i(rdat), .lk_claim_i(claim));
   pmbsr_regs #(.NUM_PHASES(4), .TELEM_CYC(TC)) dut_u (.core_clk_i, .resetn_i, .link_clk_i(lclk),
      .lk_req_i(req), .lk_cmd_i(cmd), .lk_write_i(wr_l), .lk_wdata_i(wd), .lk_busy_o(busy), .lk_ack_o(ack),
      .lk_rdata_o(rdat), .lk_claim_o(claim), .trim_check_bad_i(ev[0]), .store_checksum_bad_i(ev[1]),
      .strap_detect_bad_i(ev[2]), .self_check_busy_i(ev[3]), .followers_pending_i(ev[4]),
      .output_restore_event_i(ev[5]), .backchannel_fault_i(ev[6]), .sync_fault_i(ev[7]), .is_follower_i(ev[8]),
      .alert_suppress_misc_i(8'h00), .alert_suppress_vendor_i(mask), .phase_sel_i(phase),
      .ctrl_power_input_supply_i(ctrl), .phase_power_input_supply_i(ph), .vout_meas_i(vout), .alert_i(aw),
      .alert_o(), .alert_oe_o(aoe), .sum_misc_o(smisc), .sum_vendor_o(svf), .invalid_command_flag_o(invalid_command_flag),
      .cml_comm_fault_o(comm));

   // pulled-up alert wire shared with another device
   assign aw = ~(aoe | oth);
   always #20 core_clk_i = ~core_clk_i;
   always @(posedge core_clk_i) begin
      ivc_cnt += int'(invalid_command_flag === 1'b1);
      comm_cnt += int'(comm === 1'b1);
   end

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(negedge core_clk_i);
   endtask : cyc

   task automatic wr(input logic [7:0] c, input logic [15:0] d, output pmbsr_rsp_t rs);
      host_u.xfer(pmbsr_req_t'{c, 1'b1, d}, rs);
      cyc(1);
   endtask : wr

   task automatic rd(input logic [7:0] c, input logic [15:0] exp, input logic cl);
      pmbsr_rsp_t rs;
      host_u.xfer(pmbsr_req_t'{c, 1'b0, 16'h0000}, rs);
      cyc(1);
      chk("claim", {15'h0, cl}, {15'h0, rs.claim});
      chk("read data", exp, rs.rdata);
   endtask : rd

   task automatic hit(input int i);
      ev[i] = 1'b1;
      cyc(1);
      ev[i] = 1'b0;
   endtask : hit

   task automatic t_status();
      pmbsr_rsp_t rs;
      rd(8'h7F, 16'h0000, 1'b1);
      rd(8'h80, 16'h0000, 1'b1);
      rd(8'h55, 16'h0000, 1'b0);
      for (int i = 0; i < 8; i++) begin
         ev[i] = 1'b1;
         rd(8'h80, {8'h00, vf_bit[i]}, 1'b1);
         ev[i] = 1'b0;
         rd(8'h80, (i inside {3, 4}) ? 16'h0000 : {8'h00, vf_bit[i]}, 1'b1);
         wr(8'h80, {8'h00, vf_bit[i]}, rs);
         rd(8'h80, 16'h0000, 1'b1);
      end
      $display("status bits done");
   endtask : t_status

   task automatic t_clear();
      pmbsr_rsp_t rs;
      ev = 9'h1E1;
      cyc(1);
      ev = 9'h000;
      rd(8'h80, 16'h008E, 1'b1);
      chk("comm pulses", 16'h0001, comm_cnt[15:0]);
      wr(8'h80, 16'h0008, rs);
      rd(8'h80, 16'h0086, 1'b1);
      chk("vendor summary", 16'h0001, {15'h0, svf});
      wr(8'h03, 16'h0000, rs);
      wr(8'h80, 16'h00FF, rs);
      rd(8'h80, 16'h0000, 1'b1);
      chk("vendor summary", 16'h0000, {15'h0, svf});
      $display("clearing done");
   endtask : t_clear

   task automatic t_alert();
      pmbsr_rsp_t rs;
      mask = 8'h00;
      hit(7);
      cyc(3);
      chk("alert enable", 16'h0001, {15'h0, aoe});
      rd(8'h7F, 16'h0001, 1'b1);
      chk("misc summary", 16'h0001, {15'h0, smisc});
      wr(8'h80, 16'h0002, rs);
      chk("alert enable", 16'h0000, {15'h0, aoe});
      rd(8'h7F, 16'h0001, 1'b1);
      wr(8'h7F, 16'h0001, rs);
      rd(8'h7F, 16'h0000, 1'b1);
      chk("misc summary", 16'h0000, {15'h0, smisc});
      // another device already holds the wire low
      oth = 1'b1;
      cyc(5);
      hit(7);
      rd(8'h7F, 16'h0000, 1'b1);
      oth = 1'b0;
      wr(8'h80, 16'h0002, rs);
      mask = 8'hFF;
      $display("alert done");
   endtask : t_alert

   task automatic t_telem();
      pmbsr_rsp_t rs;
      ctrl = 16'hD2C0;
      ph = {16'h1003, 16'h1002, 16'h1001, 16'h1000};
      vout = 16'h0C00;
      cyc(TC + 2);
      rd(8'h88, 16'hD2C0, 1'b1);
      rd(8'h8B, 16'h0C00, 1'b1);
      phase = 8'h02;
      cyc(TC + 2);
      rd(8'h88, 16'h1002, 1'b1);
      ctrl = 16'hD300;
      phase = 8'h07;
      cyc(TC + 2);
      rd(8'h88, 16'hD300, 1'b1);
      wr(8'h88, 16'h1234, rs);
      wr(8'h8B, 16'h1234, rs);
      chk("invalid pulses", 16'h0002, ivc_cnt[15:0]);
      rd(8'h88, 16'hD300, 1'b1);
      $display("telemetry done");
   endtask : t_telem

   task automatic end_of_test();
      $display("checks %0d, mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : end_of_test

   initial begin
      {core_clk_i, resetn_i, oth, ev, ph, ctrl, vout} = '0;
      mask = 8'hFF;
      phase = 8'hFF;
      cyc(2);
      resetn_i = 1'b1;
      t_status();
      t_clear();
      t_alert();
      t_telem();
      end_of_test();
   end

   // the whole run needs well under 100 us
   initial begin
      #300us;
      error_cnt++;
      end_of_test();
   end
endmodule : pmbsr_regs_tb
`default_nettype wire
